// ==== rtl/iocp_regs.vh ====
// register map and field layout of the io counter prescaler
// assumes byte addressing on the register bus, one 32-bit word per register
`ifndef IOCP_REGS_VH
`define IOCP_REGS_VH

// ----------------------------------------------------------------------
// register indices and byte addresses
// ----------------------------------------------------------------------
`define IOCP_PSC_IDX      24'h306816
`define IOCP_CFG_IDX      24'h306817
`define IOCP_STS_IDX      24'h306818
`define IOCP_TCNT_IDX     24'h306819
`define IOCP_PSC_ADDR     {`IOCP_PSC_IDX, 2'b00}
`define IOCP_CFG_ADDR     {`IOCP_CFG_IDX, 2'b00}
`define IOCP_STS_ADDR     {`IOCP_STS_IDX, 2'b00}
`define IOCP_TCNT_ADDR    {`IOCP_TCNT_IDX, 2'b00}

// ----------------------------------------------------------------------
// prescaler_status_control fields and reset
// ----------------------------------------------------------------------
`define IOCP_RUN_BIT      15
`define IOCP_FRZ_BIT      14
`define IOCP_MOD_MSB      3
`define IOCP_MOD_LSB      0
`define IOCP_PSC_RST      16'h0000

// ----------------------------------------------------------------------
// module_configuration_register fields, status fields
// ----------------------------------------------------------------------
`define IOCP_STOP_BIT     0
`define IOCP_FEN_BIT      1
`define IOCP_CFG_RST      2'h0
`define IOCP_STS_FRZ_BIT  8
`define IOCP_STS_CNT_BIT  9
`define IOCP_TCNT_RST     16'h0000

// ----------------------------------------------------------------------
// modulus codes and counter values
// ----------------------------------------------------------------------
`define IOCP_MOD_CODE_16  4'h0
`define IOCP_MOD_CODE_OFF 4'h1
`define IOCP_DIV_MAX      5'h10
`define IOCP_CNT_ONE      5'h01

// ----------------------------------------------------------------------
// avalon responses
// ----------------------------------------------------------------------
`define IOCP_RESP_OKAY    2'h0
`define IOCP_RESP_DECERR  2'h3

`endif

// ==== rtl/iocp_sync.v ====
// two-stage synchroniser for a level arriving from outside the clock domain
// assumes the level is stable for more than one clock period
`timescale 1ns/1ns

module iocp_sync (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // level
  input  wire async_in,
  output reg  sync_out
);

  reg meta_q;

  // ----------------------------------------------------------------------
  // two flops, first one read only by the second
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== rtl/iocp_div.v ====
// prescaler down-counter: divides the bus clock by the decoded modulus
// assumes run, frozen and modulus_code come from flops on the same clock
`timescale 1ns/1ns
`include "iocp_regs.vh"

module iocp_div (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // control
  input  wire       run,
  input  wire       frozen,
  input  wire [3:0] modulus_code,
  // result
  output reg        tick,
  output reg  [4:0] count,
  output reg  [3:0] active_code
);

  reg running_q;

  // ----------------------------------------------------------------------
  // modulus decode
  // ----------------------------------------------------------------------
  function [4:0] decode_mod;
    input [3:0] code;
    begin
      if (code == `IOCP_MOD_CODE_16)
        decode_mod = `IOCP_DIV_MAX;                 // [RQ12]
      else
        decode_mod = {1'b0, code};                  // [RQ12] [RQ13]
    end
  endfunction

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      count       <= `IOCP_DIV_MAX;
      active_code <= `IOCP_MOD_CODE_16;
      tick        <= 1'b0;
      running_q   <= 1'b0;
    end else if (!run) begin
      // disabled: new modulus loads at once
      count       <= decode_mod(modulus_code);      // [RQ4] [RQ11]
      active_code <= modulus_code;
      tick        <= 1'b0;
      running_q   <= 1'b0;
    end else if (!running_q) begin
      // first running cycle: a modulus written together with run must win
      count       <= decode_mod(modulus_code);      // [RQ11]
      active_code <= modulus_code;
      tick        <= 1'b0;
      running_q   <= 1'b1;
    end else if (frozen) begin
      // hold the count, resume later without reload
      tick        <= 1'b0;                          // [RQ7] [RQ8]
    end else if (count == `IOCP_CNT_ONE) begin
      count       <= decode_mod(modulus_code);      // [RQ2] [RQ11]
      active_code <= modulus_code;
      tick        <= (active_code != `IOCP_MOD_CODE_OFF); // [RQ12]
    end else begin
      count       <= count - `IOCP_CNT_ONE;         // [RQ3]
      tick        <= 1'b0;
    end
  end

endmodule

// ==== rtl/iocp_top.v ====
// io counter prescaler: common counter tick for all timer submodules
// assumes an avalon-mm master on CLK and a freeze level from another domain
//
// Functional notes
// RQ1 - one divided tick, identical copy delivered to every timer submodule
// RQ2 - counter reloads the modulus on each overflow; rate is clock/modulus
// RQ3 - every division factor from 2 to 16 is available
// RQ4 - counter runs only while run_enable is set
// RQ5 - reset clears run_enable and freeze_honor
// RQ6 - freeze_honor set and freeze line active freezes the counter
// RQ7 - frozen counter holds its count and makes no ticks
// RQ8 - after freeze ends the counter resumes from the held count
// RQ9 - freeze line is stop, or freeze enable with bus freeze
// RQ10 - divide_modulus is 4-bit field in bits 12 to 15; 2 to 11 reserved (code: field in bits 0 to 3, bits 4 to 13 reserved)
// RQ11 - new modulus takes effect at count one, or at once when disabled
// RQ12 - code 0 divides by 16, 1 gives no tick, 2 and 3 divide accordingly
// RQ13 - codes 4 to 15 divide by their binary value
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "iocp_regs.vh"

module iocp_top #(
  parameter NUM_SUB = 8
) (
  // clock and reset
  input  wire               CLK,
  input  wire               RSTN,
  // avalon-mm slave
  input  wire [25:0]        AVS_ADDRESS,
  input  wire               AVS_READ,
  input  wire               AVS_WRITE,
  input  wire [31:0]        AVS_WRITEDATA,
  input  wire [3:0]         AVS_BYTEENABLE,
  output reg  [31:0]        AVS_READDATA,
  output reg  [1:0]         AVS_RESPONSE,
  output reg                AVS_WAITREQUEST,
  // subsystem internal bus freeze
  input  wire               BUS_FREEZE,
  // counter tick to the timer submodules, and the freeze line
  output reg  [NUM_SUB-1:0] COUNTER_TICK,
  output reg                FREEZE_ACTIVE
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg         run_enable_q;
  reg         run_enable_d;
  reg         freeze_honor_q;
  reg         freeze_honor_d;
  reg  [3:0]  divide_modulus_q;
  reg  [3:0]  divide_modulus_d;
  reg         stop_q;
  reg         stop_d;
  reg         freeze_en_q;
  reg         freeze_en_d;
  reg  [15:0] tick_cnt_q;
  reg  [15:0] tick_cnt_d;
  reg         counter_frozen_q;
  reg  [31:0] rdata_d;
  reg  [1:0]  resp_d;
  wire        bus_freeze_s;
  wire        div_tick;
  wire [4:0]  div_count;
  wire [3:0]  div_code;
  wire        req;
  wire        acc;
  wire        wr_acc;
  wire        hit_psc;
  wire        hit_cfg;
  wire        hit_sts;
  wire        hit_tcnt;
  wire        hit_any;
  wire [15:0] psc_word;
  wire [15:0] cfg_word;
  wire [15:0] sts_word;
  wire        clear_tcnt;

  // reset words held at full width so single fields can be picked out
  localparam [15:0] PSC_RST = `IOCP_PSC_RST;
  localparam [1:0]  CFG_RST = `IOCP_CFG_RST;

  // ----------------------------------------------------------------------
  // bus freeze synchroniser
  // ----------------------------------------------------------------------
  iocp_sync u_sync (
    .clk      (CLK),
    .rst_n    (RSTN),
    .async_in (BUS_FREEZE),
    .sync_out (bus_freeze_s)
  );

  // ----------------------------------------------------------------------
  // avalon handshake
  // ----------------------------------------------------------------------
  // one wait cycle: waitrequest drops for exactly one cycle per request
  assign req    = AVS_READ | AVS_WRITE;
  assign acc    = req & AVS_WAITREQUEST;
  assign wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;

  assign hit_psc  = (AVS_ADDRESS == `IOCP_PSC_ADDR);
  assign hit_cfg  = (AVS_ADDRESS == `IOCP_CFG_ADDR);
  assign hit_sts  = (AVS_ADDRESS == `IOCP_STS_ADDR);
  assign hit_tcnt = (AVS_ADDRESS == `IOCP_TCNT_ADDR);
  assign hit_any  = hit_psc | hit_cfg | hit_sts | hit_tcnt;

  always @(posedge CLK) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
      AVS_RESPONSE    <= `IOCP_RESP_OKAY;
    end else begin
      AVS_WAITREQUEST <= ~acc;
      if (acc) begin
        AVS_READDATA <= rdata_d;
        AVS_RESPONSE <= resp_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // reserved bits 4..13 of the control word read as zero
  assign psc_word = {run_enable_q, freeze_honor_q, 10'h000, divide_modulus_q}; // [RQ10]
  assign cfg_word = {14'h0000, freeze_en_q, stop_q};
  assign sts_word = {div_code, 2'h0,
                     run_enable_q & ~counter_frozen_q, counter_frozen_q,
                     3'h0, div_count};

  always @* begin
    rdata_d = 32'h00000000;
    resp_d  = `IOCP_RESP_OKAY;
    if (AVS_READ) begin
      if (hit_psc)
        rdata_d = {16'h0000, psc_word};
      else if (hit_cfg)
        rdata_d = {16'h0000, cfg_word};
      else if (hit_sts)
        rdata_d = {16'h0000, sts_word};
      else if (hit_tcnt)
        rdata_d = {16'h0000, tick_cnt_q};
    end
    if (!hit_any)
      resp_d = `IOCP_RESP_DECERR;
  end

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always @* begin
    run_enable_d     = run_enable_q;
    freeze_honor_d   = freeze_honor_q;
    divide_modulus_d = divide_modulus_q;
    stop_d           = stop_q;
    freeze_en_d      = freeze_en_q;
    if (wr_acc && hit_psc) begin
      if (AVS_BYTEENABLE[0])
        divide_modulus_d = AVS_WRITEDATA[`IOCP_MOD_MSB:`IOCP_MOD_LSB]; // [RQ10]
      if (AVS_BYTEENABLE[1]) begin
        run_enable_d   = AVS_WRITEDATA[`IOCP_RUN_BIT];   // [RQ4]
        freeze_honor_d = AVS_WRITEDATA[`IOCP_FRZ_BIT];   // [RQ6]
      end
    end
    if (wr_acc && hit_cfg && AVS_BYTEENABLE[0]) begin
      stop_d      = AVS_WRITEDATA[`IOCP_STOP_BIT];
      freeze_en_d = AVS_WRITEDATA[`IOCP_FEN_BIT];
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      run_enable_q     <= PSC_RST[`IOCP_RUN_BIT];  // [RQ5]
      freeze_honor_q   <= PSC_RST[`IOCP_FRZ_BIT];  // [RQ5]
      divide_modulus_q <= PSC_RST[`IOCP_MOD_MSB:`IOCP_MOD_LSB];
      stop_q           <= CFG_RST[`IOCP_STOP_BIT];
      freeze_en_q      <= CFG_RST[`IOCP_FEN_BIT];
    end else begin
      run_enable_q     <= run_enable_d;
      freeze_honor_q   <= freeze_honor_d;
      divide_modulus_q <= divide_modulus_d;
      stop_q           <= stop_d;
      freeze_en_q      <= freeze_en_d;
    end
  end

  // ----------------------------------------------------------------------
  // freeze
  // ----------------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RSTN) begin
      counter_frozen_q <= 1'b0;
      FREEZE_ACTIVE    <= 1'b0;
    end else begin
      counter_frozen_q <= freeze_honor_q & (stop_q | (freeze_en_q & bus_freeze_s)); // [RQ6]
      FREEZE_ACTIVE    <= stop_q | (freeze_en_q & bus_freeze_s);       // [RQ9]
    end
  end

  // ----------------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------------
  iocp_div u_div (
    .clk          (CLK),
    .rst_n        (RSTN),
    .run          (run_enable_q),
    .frozen       (counter_frozen_q),   // [RQ7]
    .modulus_code (divide_modulus_q),
    .tick         (div_tick),
    .count        (div_count),
    .active_code  (div_code)
  );

  // ----------------------------------------------------------------------
  // tick counter, cleared by a write to its own register; a tick in that cycle still counts
  // ----------------------------------------------------------------------
  assign clear_tcnt = wr_acc & hit_tcnt;

  always @* begin
    tick_cnt_d = tick_cnt_q;
    if (clear_tcnt)
      tick_cnt_d = `IOCP_TCNT_RST;
    if (div_tick)
      tick_cnt_d = (clear_tcnt ? `IOCP_TCNT_RST : tick_cnt_q) + 16'h0001;
  end

  always @(posedge CLK) begin
    if (!RSTN)
      tick_cnt_q <= `IOCP_TCNT_RST;
    else
      tick_cnt_q <= tick_cnt_d;
  end

  // ----------------------------------------------------------------------
  // tick fan-out: one flop per submodule keeps the copies identical
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SUB; g = g + 1) begin : g_tick
      always @(posedge CLK) begin
        if (!RSTN)
          COUNTER_TICK[g] <= 1'b0;
        else
          COUNTER_TICK[g] <= div_tick;  // [RQ1]
      end
    end
  endgenerate

endmodule

// ==== testbench/iocp_top_assertions.sv ====
// checker for the io counter prescaler top, bound to its ports
// assumes an avalon-mm master that holds requests until waitrequest is low
`timescale 1ns/1ns
`include "iocp_regs.vh"
module iocp_chk #(
  parameter NUM_SUB = 8
) (
  input wire logic               CLK,
  input wire logic               RSTN,
  input wire logic [25:0]        AVS_ADDRESS,
  input wire logic               AVS_READ,
  input wire logic               AVS_WRITE,
  input wire logic [31:0]        AVS_WRITEDATA,
  input wire logic [3:0]         AVS_BYTEENABLE,
  input wire logic               AVS_WAITREQUEST,
  input wire logic               BUS_FREEZE,
  input wire logic [NUM_SUB-1:0] COUNTER_TICK,
  input wire logic               FREEZE_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // shadow of the control bits, taken at the edge the write lands
  logic run_q, hon_q, stop_q, fen_q;
  wire  acc_w = AVS_WRITE && !AVS_WAITREQUEST;
  always @(posedge CLK) begin
    if (!RSTN) begin
      {run_q, hon_q, stop_q, fen_q} <= 4'h0;
    end else if (acc_w && AVS_BYTEENABLE[1] && AVS_ADDRESS == `IOCP_PSC_ADDR) begin
      {run_q, hon_q} <= AVS_WRITEDATA[15:14];
    end else if (acc_w && AVS_BYTEENABLE[0] && AVS_ADDRESS == `IOCP_CFG_ADDR) begin
      {fen_q, stop_q} <= AVS_WRITEDATA[1:0];
    end
  end
  ticks_equal_a: assert property (COUNTER_TICK == '0 || COUNTER_TICK == '1)
    else $error("tick copies differ");
  tick_single_a: assert property (|COUNTER_TICK |=> COUNTER_TICK == '0)
    else $error("tick longer than one cycle");
  wait_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  wait_pulse_a: assert property ($fell(AVS_WAITREQUEST) |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  reset_quiet_a: assert property (disable iff (1'b0) !RSTN |=> AVS_WAITREQUEST && COUNTER_TICK == '0 && !FREEZE_ACTIVE)
    else $error("outputs not quiet after reset");
  stopped_quiet_a: assert property ((!run_q)[*3] |-> COUNTER_TICK == '0)
    else $error("tick while disabled");
  frozen_quiet_a: assert property ((FREEZE_ACTIVE && hon_q)[*4] |-> COUNTER_TICK == '0)
    else $error("tick while frozen");
  stop_freeze_a: assert property (stop_q[*2] |-> FREEZE_ACTIVE)
    else $error("stop does not raise freeze line");
  no_freeze_a: assert property ((!stop_q && !fen_q)[*3] |-> !FREEZE_ACTIVE)
    else $error("freeze line without cause");
endmodule
bind iocp_top iocp_chk #(.NUM_SUB(NUM_SUB)) iocp_chk_i (.CLK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
  .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_WAITREQUEST, .BUS_FREEZE, .COUNTER_TICK, .FREEZE_ACTIVE);

// ==== testbench/iocp_sub_model.sv ====
// timer submodule model: counts common ticks and measures their spacing
// assumes the tick is a one-cycle pulse on clk
`timescale 1ns/1ns
module iocp_sub_model (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic [7:0] tick,
  output logic      [15:0] n_ticks,
  output logic      [7:0]  gap
);
  logic [7:0] since_q = 8'h00;
  initial n_ticks = 16'h0000;
  initial gap = 8'h00;
  // consumes copy 0 only; the checker asserts that the copies are equal
  always @(posedge clk) begin
    since_q <= tick[0] ? 8'h01 : since_q + 8'h01;
    if (tick[0]) begin
      gap <= since_q;
    end
    n_ticks <= clr ? 16'h0000 : n_ticks + {15'h0000, tick[0]};
  end
endmodule

// ==== testbench/iocp_top_tb.sv ====
// self-checking bench for the io counter prescaler top
// assumes the checker is bound from its own file
`timescale 1ns/1ns
`include "iocp_regs.vh"
module iocp_top_tb;
  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, bus_frz = 0, clr = 0;
  logic [25:0] adr = 26'h0000000;
  logic [31:0] wd = 32'h00000000, rdat;
  logic [1:0]  resp;
  logic [3:0]  be = 4'hF;
  wire  [31:0] rdata;
  wire  [1:0]  rsp;
  wire         wreq, frz;
  wire  [7:0]  tick, gap;
  wire  [15:0] nt;
  int          n_errors = 0, checks = 0, c0, c1;
  logic [7:0]  per_tab [16] = '{16, 0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15};
  always #5 clk = ~clk;
  iocp_top iocp_top_i (.CLK(clk), .RSTN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_RESPONSE(rsp),
    .AVS_WAITREQUEST(wreq), .BUS_FREEZE(bus_frz), .COUNTER_TICK(tick), .FREEZE_ACTIVE(frz));
  iocp_sub_model iocp_sub_model_i (.clk(clk), .clr(clr), .tick(tick), .n_ticks(nt), .gap(gap));
  task automatic wr_reg(input logic [25:0] a, input logic [15:0] d);
    @(posedge clk); adr <= a; wd <= {16'h0000, d}; wr <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [25:0] a);
    @(posedge clk); adr <= a; rd <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    rdat = rdata; resp = rsp; rd <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // count ticks over a window that starts fresh
  task automatic window(input int n);
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic close_out;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`IOCP_TCNT_ADDR + 26'h0000004);
    chk(resp, `IOCP_RESP_DECERR, "unmapped resp");
    chk(rdat, 32'h00000000, "unmapped data");
    wr_reg(`IOCP_PSC_ADDR, 16'hFFFF);
    rd_reg(`IOCP_PSC_ADDR);
    chk(rdat, 32'h0000C00F, "reserved bits");
    chk(resp, `IOCP_RESP_OKAY, "mapped resp");
    // modulus changes while running: each lands at the next reload
    for (int i = 0; i < 16; i++) begin
      wr_reg(`IOCP_PSC_ADDR, 16'h8000 | i);
      rd_reg(`IOCP_PSC_ADDR);
      chk(rdat, 32'h00008000 | i, "modulus rw");
      repeat (40) @(posedge clk);
      window(40);
      if (per_tab[i] == 8'h00) chk(nt, 0, "code one ticks");
      else chk(gap, per_tab[i], "tick period");
    end
    wr_reg(`IOCP_PSC_ADDR, 16'h0002);
    window(20);
    chk(nt, 0, "disabled ticks");
    wr_reg(`IOCP_TCNT_ADDR, 16'h0000);
    wr_reg(`IOCP_PSC_ADDR, 16'hC00F);
    // modulus written with run: first period already uses it
    c1 = 0;
    while (tick[0] !== 1'b1 && c1 < 40) begin
      @(posedge clk);
      c1++;
    end
    chk(c1, 18, "first tick after start");
    rd_reg(`IOCP_TCNT_ADDR);
    chk(rdat, 32'h00000001, "tick count");
    repeat (7) @(posedge clk);
    wr_reg(`IOCP_CFG_ADDR, 16'h0001);
    repeat (4) @(posedge clk);
    chk(frz, 1, "stop freeze");
    rd_reg(`IOCP_STS_ADDR);
    c0 = rdat[4:0];
    chk(rdat[15:8], 8'hF1, "frozen status");
    window(30);
    chk(nt, 0, "frozen ticks");
    rd_reg(`IOCP_STS_ADDR);
    chk(rdat[4:0], c0, "held count");
    wr_reg(`IOCP_CFG_ADDR, 16'h0000);
    c1 = 0;
    while (tick[0] !== 1'b1 && c1 < 40) begin
      @(posedge clk);
      c1++;
    end
    chk(c1, c0 + 3, "resume from held");
    wr_reg(`IOCP_PSC_ADDR, 16'h800F);
    wr_reg(`IOCP_CFG_ADDR, 16'h0002);
    bus_frz <= 1'b1;
    window(32);
    chk(frz, 1, "bus freeze line");
    chk(nt != 0, 1, "freeze ignored");
    wr_reg(`IOCP_PSC_ADDR, 16'hC00F);
    // let a tick launched before the freeze took hold drain
    repeat (2) @(posedge clk);
    window(32);
    chk(nt, 0, "freeze honored");
    bus_frz <= 1'b0;
    repeat (8) @(posedge clk);
    chk(frz, 0, "freeze released");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`IOCP_PSC_ADDR);
    chk(rdat, 32'h00000000, "control reset");
    be <= 4'h1;
    wr_reg(`IOCP_PSC_ADDR, 16'hC003);
    be <= 4'hF;
    rd_reg(`IOCP_PSC_ADDR);
    chk(rdat, 32'h00000003, "lane 0 only");
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule
